//--- src/bts_supervisor.sv
// Bus timeout supervisor: confirm window, off-line entry, LIN wake, clamp and TX guard.
// Assumes a mode controller drives MODE_I and acts on the status it reports.
`timescale 1ns/1ps
module bts_supervisor (
    input  wire logic                 SYS_CLK_I,
    input  wire logic                 RST_I,
    input  wire bts_pkg::bts_mode_t   MODE_I,
    input  wire logic                 CAN_WAKE_EVT_I,
    input  wire logic                 WAKE_MSG_I,
    input  wire logic                 CONFIRM_MSG_I,
    input  wire logic                 CAN_ACTIVITY_I,
    input  wire logic                 CAN_TRANSMIT_INPUT_I,
    input  wire logic                 LIN_TRANSMIT_INPUT_I,
    input  wire logic                 LIN_BUS_I,
    input  wire logic                 CAN_REGULATOR_CONTROL_BIT_I,
    input  wire logic                 OFFLINE_TIMER_SELECT_I,
    output bts_pkg::bts_status_t      STATUS_O,
    output logic                      LIN_TX_ENABLE_O
);
    // =====================================================
    // Pin synchronisers
    // =====================================================
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic       can_tx_s;
    logic       lin_tx_s;
    logic       lin_bus_s;

    // Two flops on each asynchronous pin
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            pin_meta_q <= 3'h7;
            pin_sync_q <= 3'h7;
        end else begin
            pin_meta_q <= {CAN_TRANSMIT_INPUT_I, LIN_TRANSMIT_INPUT_I, LIN_BUS_I};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Synchronised pins, all idle high after reset
    assign can_tx_s  = pin_sync_q[2];
    assign lin_tx_s  = pin_sync_q[1];
    assign lin_bus_s = pin_sync_q[0];

    // =====================================================
    // Microsecond tick divider
    // =====================================================
    logic [bts_pkg::TICK_CNT_W-1:0] div_q;
    logic                           tick;

    assign tick = (div_q == bts_pkg::TICK_LAST);

    // Free-running divider
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            div_q <= '0;
        end else begin
            div_q <= tick ? '0 : div_q + 1'b1;
        end
    end

    // =====================================================
    // Mode decode and sticky state
    // =====================================================
    logic mode_active;
    logic mode_offline;
    logic mode_listen;
    logic mode_online_any;
    logic waiting_q;
    logic can_woken_q;
    logic clamped_q;
    logic tx_dis_q;
    logic timeout_q;

    assign mode_active     = (MODE_I == bts_pkg::BTS_MODE_ACTIVE);
    assign mode_offline    = (MODE_I == bts_pkg::BTS_MODE_OFFLINE);
    assign mode_listen     = (MODE_I == bts_pkg::BTS_MODE_LISTEN);
    assign mode_online_any = mode_listen || (MODE_I == bts_pkg::BTS_MODE_ONLINE);

    // =====================================================
    // Timer conditions and limits
    // =====================================================
    logic [bts_pkg::NUM_TMR-1:0]    cond;
    logic [bts_pkg::NUM_TMR-1:0]    expired;
    logic [bts_pkg::TMR_W-1:0]      limit [bts_pkg::NUM_TMR];
    logic [bts_pkg::TMR_W-1:0]      offl_limit;

    // Idle limit picked by wake origin, then select bit
    assign offl_limit = can_woken_q            ? bts_pkg::OFFL_EXT_TICKS :
                        OFFLINE_TIMER_SELECT_I ? bts_pkg::OFFL_LONG_TICKS :
                                                 bts_pkg::OFFL_TICKS;

    // Each condition drops to restart its timer
    assign cond[0]  = mode_listen && waiting_q && !CONFIRM_MSG_I;
    assign cond[1]  = mode_online_any && can_tx_s && CAN_REGULATOR_CONTROL_BIT_I
                      && !CAN_ACTIVITY_I;
    assign cond[2]  = mode_offline && !lin_bus_s;
    assign cond[3]  = mode_active && !lin_bus_s && !clamped_q;
    assign cond[4]  = mode_active && lin_bus_s && clamped_q;
    assign cond[5]  = mode_active && !lin_tx_s && !tx_dis_q;
    // Expiry counts in microsecond ticks
    assign limit[0] = bts_pkg::CONFIRM_TICKS;
    assign limit[1] = offl_limit;
    assign limit[2] = bts_pkg::LWAKE_TICKS;
    assign limit[3] = bts_pkg::CLAMP_TICKS;
    assign limit[4] = bts_pkg::RECOV_TICKS;
    assign limit[5] = bts_pkg::TXDIS_TICKS;

    // One timer per supervised condition
    genvar gi;
    generate
        for (gi = 0; gi < bts_pkg::NUM_TMR; gi++) begin : g_tmr
            bts_timer u_tmr (
                .clk_i     (SYS_CLK_I),
                .rst_i     (RST_I),
                .tick_i    (tick),
                .cond_i    (cond[gi]),
                .limit_i   (limit[gi]),
                .expired_o (expired[gi])
            );
        end
    endgenerate

    // =====================================================
    // Sticky state updates
    // =====================================================
    // Wake message arms the confirm window; confirm, timeout or a mode change ends it
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            waiting_q <= 1'b0;
        end else if (!mode_listen || CONFIRM_MSG_I || expired[0]) begin
            waiting_q <= 1'b0;
        end else if (WAKE_MSG_I) begin
            waiting_q <= 1'b1;
        end
    end

    // Confirm timeout report; the window closes right after, so it pulses
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            timeout_q <= 1'b0;
        end else begin
            timeout_q <= mode_listen && expired[0];
        end
    end

    // CAN wake origin held through on-line and off-line; the event wins over the clear
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            can_woken_q <= 1'b0;
        end else if (CAN_WAKE_EVT_I) begin
            can_woken_q <= 1'b1;
        end else if (!mode_online_any && !mode_offline) begin
            can_woken_q <= 1'b0;
        end
    end

    // Clamp set and recovery, active mode only
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            clamped_q <= 1'b0;
        end else if (!mode_active) begin
            clamped_q <= 1'b0;
        end else if (expired[3]) begin
            clamped_q <= 1'b1;
        end else if (expired[4]) begin
            clamped_q <= 1'b0;
        end
    end

    // Transmitter disable, released once the input goes recessive
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            tx_dis_q <= 1'b0;
        end else if (!mode_active || lin_tx_s) begin
            tx_dis_q <= 1'b0;
        end else if (expired[5]) begin
            tx_dis_q <= 1'b1;
        end
    end

    // =====================================================
    // Outputs
    // =====================================================
    logic lwake_q;
    logic offl_q;

    // LIN wake level, held while the dominant lasts
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            lwake_q <= 1'b0;
        end else begin
            lwake_q <= expired[2];
        end
    end

    // Off-line request, held while the bus stays idle
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            offl_q <= 1'b0;
        end else begin
            offl_q <= expired[1];
        end
    end

    // Status fields, one driver for the whole carrier
    assign STATUS_O = '{confirm_timeout: timeout_q,
                        go_offline:      offl_q,
                        lin_wake:        lwake_q,
                        lin_clamped:     clamped_q,
                        lin_tx_disabled: tx_dis_q};
    assign LIN_TX_ENABLE_O = !tx_dis_q;
endmodule // bts_supervisor

//--- pkg/bts_pkg.sv
// Package for the bus timeout supervisor: modes, carriers and timing counts.
// Assumes a 125 MHz system clock and a 1 us tick made by the divider inside the supervisor module.
package bts_pkg;

    // ==========================================================
    // Clock and tick
    // ==========================================================
    localparam int CLK_MHZ          = 125;
    localparam int TICK_NS          = 1000;
    localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
    localparam int TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_CNT_W       = 7;
    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);

    // ==========================================================
    // Times in their printed units; the design expires at the midpoint
    // of each window, which lies inside both the least and the longest time
    // ==========================================================
    localparam int CONFIRM_MIN_MS   = 115;
    localparam int CONFIRM_MAX_MS   = 285;
    localparam int OFFL_MIN_MS      = 50;
    localparam int OFFL_MAX_MS      = 66;
    localparam int OFFL_LONG_MIN_MS = 200;
    localparam int OFFL_LONG_MAX_MS = 265;
    localparam int OFFL_EXT_MIN_MS  = 400;
    localparam int OFFL_EXT_MAX_MS  = 530;
    localparam int LWAKE_MIN_US     = 30;
    localparam int LWAKE_MAX_US     = 150;
    localparam int CLAMP_MIN_MS     = 40;
    localparam int CLAMP_MAX_MS     = 160;
    localparam int RECOV_MIN_US     = 800;
    localparam int RECOV_MAX_US     = 2200;
    localparam int TXDIS_MIN_MS     = 20;
    localparam int TXDIS_MAX_MS     = 80;

    // Counts of 1 us ticks at each window's centre
    localparam int TMR_W = 20;
    localparam logic [TMR_W-1:0] CONFIRM_TICKS =
        TMR_W'((CONFIRM_MIN_MS + CONFIRM_MAX_MS) * 500);
    localparam logic [TMR_W-1:0] OFFL_TICKS =
        TMR_W'((OFFL_MIN_MS + OFFL_MAX_MS) * 500);
    localparam logic [TMR_W-1:0] OFFL_LONG_TICKS =
        TMR_W'((OFFL_LONG_MIN_MS + OFFL_LONG_MAX_MS) * 500);
    localparam logic [TMR_W-1:0] OFFL_EXT_TICKS =
        TMR_W'((OFFL_EXT_MIN_MS + OFFL_EXT_MAX_MS) * 500);
    localparam logic [TMR_W-1:0] LWAKE_TICKS =
        TMR_W'((LWAKE_MIN_US + LWAKE_MAX_US) / 2);
    localparam logic [TMR_W-1:0] CLAMP_TICKS =
        TMR_W'((CLAMP_MIN_MS + CLAMP_MAX_MS) * 500);
    localparam logic [TMR_W-1:0] RECOV_TICKS =
        TMR_W'((RECOV_MIN_US + RECOV_MAX_US) / 2);
    localparam logic [TMR_W-1:0] TXDIS_TICKS =
        TMR_W'((TXDIS_MIN_MS + TXDIS_MAX_MS) * 500);

    // Number of supervision timers
    localparam int NUM_TMR = 6;

    // ==========================================================
    // Modes supplied by the mode controller
    // ==========================================================
    typedef enum logic [2:0] {
        BTS_MODE_ACTIVE,
        BTS_MODE_ONLINE,
        BTS_MODE_LISTEN,
        BTS_MODE_OFFLINE,
        BTS_MODE_OTHER
    } bts_mode_t;

    // Status carrier toward the mode controller
    typedef struct packed {
        logic confirm_timeout;
        logic go_offline;
        logic lin_wake;
        logic lin_clamped;
        logic lin_tx_disabled;
    } bts_status_t;

endpackage

//--- src/bts_timer.sv
// Qualified-duration timer: counts ticks while its condition holds.
// Assumes the tick is a one-cycle enable on the same clock.
`timescale 1ns/1ps
module bts_timer (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      tick_i,
    input  wire logic                      cond_i,
    input  wire logic [bts_pkg::TMR_W-1:0] limit_i,
    output logic                           expired_o
);
    logic [bts_pkg::TMR_W-1:0] cnt_q;
    logic [bts_pkg::TMR_W-1:0] cnt_d;
    logic                      hit;

    // =====================================================
    // Count logic
    // =====================================================
    // Reaching the limit saturates; a broken condition restarts
    assign hit       = (cnt_q >= limit_i);
    assign cnt_d     = !cond_i ? '0 : (tick_i && !hit) ? cnt_q + 1'b1 : cnt_q;
    assign expired_o = cond_i && hit;

    // Count register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // bts_timer

//--- testbench/bts_bus_model.sv
// LIN bus and host pin model standing at the far side of the supervisor.
// Assumes the bus has a pull-up, so a released bus reads recessive (1).
`timescale 1ns/1ps
module bts_bus_model (
    input  wire logic other_dom_i,
    input  wire logic host_txd_i,
    input  wire logic tx_en_i,
    output logic      lin_bus_o,
    output logic      lin_txd_o
);
    // ==========================================================
    // Host pin and wired-AND bus
    // ==========================================================
    // Host transmit pin passes straight through
    assign lin_txd_o = host_txd_i;
    // Dominant when another node pulls low or our enabled transmitter drives low
    assign lin_bus_o = !(other_dom_i || (!host_txd_i && tx_en_i));
endmodule // bts_bus_model

//--- testbench/bts_supervisor_asserts.sv
// Checker for the supervisor top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module bts_supervisor_asserts (
    input wire logic               SYS_CLK_I,
    input wire logic               RST_I,
    input wire bts_pkg::bts_mode_t MODE_I,
    input wire logic               CAN_ACTIVITY_I,
    input wire logic               CAN_TRANSMIT_INPUT_I,
    input wire logic               LIN_TRANSMIT_INPUT_I,
    input wire logic               LIN_BUS_I,
    input wire logic               CAN_REGULATOR_CONTROL_BIT_I,
    input wire bts_pkg::bts_status_t STATUS_O,
    input wire logic               LIN_TX_ENABLE_O
);
    // Least and latest counts in system clock cycles; the latest allows for sync delay
    localparam int CYC_US    = bts_pkg::TICK_CYCLES;
    localparam int WAKE_MIN  = bts_pkg::LWAKE_MIN_US * CYC_US;
    localparam int WAKE_MAX  = bts_pkg::LWAKE_MAX_US * CYC_US + 10;
    localparam int CLAMP_MIN = bts_pkg::CLAMP_MIN_MS * 1000 * CYC_US;
    localparam int RECOV_MIN = bts_pkg::RECOV_MIN_US * CYC_US;
    localparam int TXD_MIN   = bts_pkg::TXDIS_MIN_MS * 1000 * CYC_US;
    localparam int IDLE_MIN  = bts_pkg::OFFL_MIN_MS * 1000 * CYC_US;
    int  wake_q;
    int  clamp_q;
    int  rec_q;
    int  txd_q;
    int  idle_q;
    wire act_w = (MODE_I == bts_pkg::BTS_MODE_ACTIVE);
    wire idle_w = (MODE_I == bts_pkg::BTS_MODE_ONLINE || MODE_I == bts_pkg::BTS_MODE_LISTEN)
                  && CAN_TRANSMIT_INPUT_I && CAN_REGULATOR_CONTROL_BIT_I && !CAN_ACTIVITY_I;
    // ==========================================================
    // Cycles each qualifying condition has held
    // ==========================================================
    always_ff @(posedge SYS_CLK_I) begin
        wake_q  <= (RST_I || LIN_BUS_I || MODE_I != bts_pkg::BTS_MODE_OFFLINE) ? 0 : wake_q + 1;
        clamp_q <= (RST_I || LIN_BUS_I || !act_w) ? 0 : clamp_q + 1;
        rec_q   <= (RST_I || !LIN_BUS_I || !act_w) ? 0 : rec_q + 1;
        txd_q   <= (RST_I || LIN_TRANSMIT_INPUT_I || !act_w) ? 0 : txd_q + 1;
        idle_q  <= (RST_I || !idle_w) ? 0 : idle_q + 1;
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // ==========================================================
    // Properties
    // ==========================================================
    reset_clear_a: assert property ($past(RST_I) |-> STATUS_O == '0 && LIN_TX_ENABLE_O)
        else $error("status not clear after reset");
    wake_early_a: assert property ($rose(STATUS_O.lin_wake) |-> wake_q >= WAKE_MIN)
        else $error("lin wake too early");
    wake_late_a: assert property (wake_q == WAKE_MAX |-> STATUS_O.lin_wake)
        else $error("lin wake missing");
    wake_mode_a: assert property ($rose(STATUS_O.lin_wake) |->
        $past(MODE_I) == bts_pkg::BTS_MODE_OFFLINE)
        else $error("lin wake outside off-line");
    wake_drop_a: assert property (STATUS_O.lin_wake && LIN_BUS_I |->
        ##[1:4] !STATUS_O.lin_wake)
        else $error("lin wake held after recessive");
    clamp_early_a: assert property ($rose(STATUS_O.lin_clamped) |->
        clamp_q >= CLAMP_MIN)
        else $error("clamp flagged too early");
    recov_early_a: assert property ($fell(STATUS_O.lin_clamped) &&
        $past(MODE_I) == bts_pkg::BTS_MODE_ACTIVE |-> rec_q >= RECOV_MIN)
        else $error("clamp cleared too early");
    txdis_early_a: assert property ($rose(STATUS_O.lin_tx_disabled) |->
        txd_q >= TXD_MIN)
        else $error("transmitter disabled too early");
    txdis_pin_a: assert property ($rose(STATUS_O.lin_tx_disabled) |->
        ##[0:1] !LIN_TX_ENABLE_O)
        else $error("transmitter enable still high");
    offl_early_a: assert property ($rose(STATUS_O.go_offline) |-> idle_q >= IDLE_MIN)
        else $error("off-line entered too early");
    confirm_mode_a: assert property ($rose(STATUS_O.confirm_timeout) |->
        $past(MODE_I) == bts_pkg::BTS_MODE_LISTEN)
        else $error("confirm timeout outside listen");
endmodule // bts_supervisor_asserts
bind bts_supervisor bts_supervisor_asserts bts_supervisor_asserts_i (.*);

//--- testbench/tb.sv
// Self-checking bench for the supervisor, with the bus model at its far side.
// Assumes full-length counts, so only the LIN wake timer is run to expiry.
`timescale 1ns/1ps
module tb;
    logic               clk, rst, can_wake, wake_msg, confirm, can_act;
    logic               can_txd, reg_bit, sel, other_dom, host_txd;
    logic               lin_bus, lin_txd, tx_en;
    bts_pkg::bts_mode_t mode;
    bts_pkg::bts_status_t status;
    int                 miscompares, samples_checked;
    // ==========================================================
    // Clock, design and far side
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    bts_supervisor bts_supervisor_i (.SYS_CLK_I(clk), .RST_I(rst), .MODE_I(mode),
        .CAN_WAKE_EVT_I(can_wake), .WAKE_MSG_I(wake_msg), .CONFIRM_MSG_I(confirm),
        .CAN_ACTIVITY_I(can_act), .CAN_TRANSMIT_INPUT_I(can_txd),
        .LIN_TRANSMIT_INPUT_I(lin_txd), .LIN_BUS_I(lin_bus),
        .CAN_REGULATOR_CONTROL_BIT_I(reg_bit), .OFFLINE_TIMER_SELECT_I(sel),
        .STATUS_O(status), .LIN_TX_ENABLE_O(tx_en));
    bts_bus_model bts_bus_model_i (.other_dom_i(other_dom), .host_txd_i(host_txd),
        .tx_en_i(tx_en), .lin_bus_o(lin_bus), .lin_txd_o(lin_txd));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Holds n cycles and reports any masked status bit or a dropped enable
    task automatic quiet(input string what, input bts_pkg::bts_status_t m, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if ((status & m) !== '0 || tx_en !== 1'b1) bad = 1'b1;
        end
        check(what, 1'b0, bad);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_lin_wake();
        int n;
        @(posedge clk);
        mode <= bts_pkg::BTS_MODE_OFFLINE;
        other_dom <= 1'b1;
        quiet("lin_wake early", 5'h04, 3700);
        n = 0;
        while (status.lin_wake !== 1'b1 && n < 15050) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("lin_wake", 1'b1, status.lin_wake);
        if (n >= 15050) conclude();
        @(posedge clk);
        other_dom <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check("lin_wake release", 1'b0, status.lin_wake);
        $display("test lin_wake done");
    endtask
    task automatic t_short_pulses();
        repeat (5) begin
            @(posedge clk);
            other_dom <= 1'b1;
            quiet("short pulse", 5'h04, 3125);
            other_dom <= 1'b0;
            quiet("pulse gap", 5'h04, 4);
        end
        $display("test short_pulses done");
    endtask
    task automatic t_active_dominant();
        @(posedge clk);
        mode <= bts_pkg::BTS_MODE_ACTIVE;
        host_txd <= 1'b0;
        quiet("clamp and tx guard", 5'h03, 20000);
        host_txd <= 1'b1;
        quiet("active release", 5'h03, 10);
        $display("test active_dominant done");
    endtask
    task automatic t_can_idle();
        @(posedge clk);
        mode <= bts_pkg::BTS_MODE_ONLINE;
        quiet("idle early", 5'h18, 8000);
        sel <= 1'b1;
        quiet("long idle early", 5'h18, 6000);
        can_act <= 1'b1;
        quiet("idle restart", 5'h18, 4);
        can_act <= 1'b0;
        can_wake <= 1'b1;
        quiet("ext idle early", 5'h18, 1);
        can_wake <= 1'b0;
        quiet("ext idle early", 5'h18, 6000);
        mode <= bts_pkg::BTS_MODE_LISTEN;
        wake_msg <= 1'b1;
        quiet("confirm early", 5'h10, 1);
        wake_msg <= 1'b0;
        quiet("confirm early", 5'h18, 5000);
        confirm <= 1'b1;
        quiet("confirm ends wait", 5'h18, 1);
        confirm <= 1'b0;
        quiet("after confirm", 5'h18, 4000);
        $display("test can_idle done");
    endtask
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        {rst, can_wake, wake_msg, confirm, can_act, sel, other_dom} = 7'h40;
        {can_txd, reg_bit, host_txd} = 3'h7;
        mode = bts_pkg::BTS_MODE_OTHER;
        miscompares = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        #1;
        check("status in reset", 1'b0, |status);
        check("tx enable in reset", 1'b1, tx_en);
        rst <= 1'b0;
        t_lin_wake();
        t_short_pulses();
        t_active_dominant();
        t_can_idle();
        conclude();
    end
endmodule // tb
